/* File: core/pic_defs.svh */
// register map, command codes and reset values of the cascaded controller pair
// How it works
// [RL1] a one in a mask bit blocks that request line
// [RL2] a zero in a mask bit lets that line be accepted again
// [RL3] master mask bit 2 also blocks everything coming from the slave
// [RL4] reset or init leaves each controller fully nested, line 0 first
// [RL5] reset or init turns rotation off; plain end_of_interrupt is the default
// [RL6] code 000 clears, code 100 sets rotation in automatic end mode
// [RL7] 001 non-specific end, 011 specific end, 101 end with rotate, 010 nothing
// [RL8] code 110 sets priority from the level_select_bits
// [RL9] code 111 ends the selected line and rotates on it
// [RL10] the command word counts only when bits 4:3 are 00
// [RL11] level_select_bits 0..7 name line 0..7 (slave: 8..15)
// [RL12] slave output drives master line 2 and is resolved there
// [RL13] automatic_interrupt_end ends each interrupt at acknowledge
// [RL14] line 0 highest by default; rotation makes the served line lowest
// [RL15] non-specific end clears highest in-service line, specific the selected one
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

`define PIC_IDX_MCMD 10'h020
`define PIC_IDX_MMASK 10'h021
`define PIC_IDX_SCMD 10'h0a0
`define PIC_IDX_SMASK 10'h0a1
`define PIC_IDX_CFG 10'h030
`define PIC_IDX_STAT 10'h031
`define PIC_IDX_EN 10'h032
`define PIC_IDX_CLR 10'h033
`define PIC_IDX_ISR 10'h034
`define PIC_IDX_PEND 10'h035

`define PIC_CFG_AUTO_M 0
`define PIC_CFG_AUTO_S 1
`define PIC_CFG_INIT 4

`define PIC_OP_ROT_AUTO_CLR 3'h0
`define PIC_OP_NS_EOI 3'h1
`define PIC_OP_NOP 3'h2
`define PIC_OP_SP_EOI 3'h3
`define PIC_OP_ROT_AUTO_SET 3'h4
`define PIC_OP_ROT_NS 3'h5
`define PIC_OP_SET_PRIO 3'h6
`define PIC_OP_ROT_SP 3'h7

`define PIC_MASK_RST 8'h00
`define PIC_BASE_RST 3'h7
`define PIC_CASCADE_LINE 3'h2

`endif

/* File: core/pic_pkg.sv */
// types shared by the controller pair
`default_nettype none
package pic_pkg;
   typedef struct packed {
      logic [2:0] code;
      logic [1:0] sel;
      logic [2:0] level;
   } pic_cmd_type;
   typedef struct packed {
      logic valid;
      logic [3:0] line;
   } pic_ack_type;
endpackage
`default_nettype wire

/* File: core/pic_prio.sv */
// rotating priority picker: best set bit after the lowest-priority base
`default_nettype none
module pic_prio (
   input wire logic [7:0] vec,
   input wire logic [2:0] base,
   output logic found,
   output logic [2:0] line,
   output logic [2:0] rank
);
   always_comb begin
      found = 1'b0;
      line = 3'h0;
      rank = 3'h0;
      for (int k = 7; k >= 0; k--) begin
         if (vec[3'(base + 3'(k) + 3'h1)]) begin
            found = 1'b1;
            line = 3'(base + 3'(k) + 3'h1);
            rank = 3'(k);
         end
      end
   end
endmodule
`default_nettype wire

/* File: core/pic_sync.sv */
// two-stage synchroniser for the request pins
`default_nettype none
module pic_sync #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q <= '0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule
`default_nettype wire

/* File: core/pic_top.sv */
// cascaded controller pair: masks, end and rotate commands, apb registers
//
// The implementer's own choice: the APB interface to the registers.
`include "pic_defs.svh"
`default_nettype none
module pic_top import pic_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] irq_in,
   output logic intr,
   input wire logic int_ack,
   output logic ack_valid,
   output logic [3:0] ack_line,
   output logic irq_out
);

   // ***********************
   // request pins and bus decode
   // ***********************
   logic [15:0] irq_s;
   logic [9:0] idx;
   logic hit;
   logic wr_acc;
   logic init_pulse;
   pic_cmd_type cmd;

   pic_sync #(.WIDTH(16)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(irq_in),
      .q(irq_s)
   );

   assign idx = paddr[11:2];
   assign cmd = pic_cmd_type'(pwdata[7:0]);
   assign wr_acc = psel & penable & pwrite & hit;
   assign init_pulse = wr_acc & (idx == `PIC_IDX_CFG) & pwdata[`PIC_CFG_INIT];

   always_comb begin
      case (idx)
         `PIC_IDX_MCMD, `PIC_IDX_MMASK, `PIC_IDX_SCMD, `PIC_IDX_SMASK,
         `PIC_IDX_CFG, `PIC_IDX_STAT, `PIC_IDX_EN, `PIC_IDX_CLR,
         `PIC_IDX_ISR, `PIC_IDX_PEND: hit = (paddr[1:0] == 2'h0);
         default: hit = 1'b0;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // ***********************
   // per-controller state
   // ***********************
   logic [1:0][7:0] mask_ff;
   logic [1:0][7:0] isr_ff;
   logic [1:0][2:0] base_ff;
   logic [1:0] rot_auto_ff;
   logic [1:0] auto_end_ff;
   logic [1:0][7:0] req_w;
   logic [1:0][7:0] pend_w;
   logic [1:0] intr_w;
   logic [1:0] acc;
   logic [1:0] cmd_wr;
   logic [1:0] eoi_ev;
   logic [1:0][2:0] win;

   // slave output enters master line 2
   assign req_w[0] = {irq_s[7:3], intr_w[1], irq_s[1:0]}; // RL12
   assign req_w[1] = irq_s[15:8];

   // acknowledge reaches the slave only when master line 2 won
   assign acc[0] = int_ack & intr_w[0];
   assign acc[1] = acc[0] & (win[0] == `PIC_CASCADE_LINE); // RL12

   for (genvar c = 0; c < 2; c++) begin : g_ctl
      localparam logic [9:0] CIDX = (c == 0) ? `PIC_IDX_MCMD : `PIC_IDX_SCMD;
      localparam logic [9:0] MIDX = (c == 0) ? `PIC_IDX_MMASK : `PIC_IDX_SMASK;
      logic pend_any;
      logic isr_any;
      logic [2:0] pend_rank;
      logic [2:0] isr_line;
      logic [2:0] isr_rank;
      logic [7:0] set_v;
      logic [7:0] clr_v;
      logic base_ld;
      logic [2:0] base_val;

      assign pend_w[c] = req_w[c] & ~mask_ff[c]; // RL1 RL2 RL3

      pic_prio u_pend (
         .vec(pend_w[c]),
         .base(base_ff[c]),
         .found(pend_any),
         .line(win[c]),
         .rank(pend_rank)
      );

      pic_prio u_isr (
         .vec(isr_ff[c]),
         .base(base_ff[c]),
         .found(isr_any),
         .line(isr_line),
         .rank(isr_rank)
      );

      // request only when it outranks every line in service
      assign intr_w[c] = pend_any & (~isr_any | (pend_rank < isr_rank)); // RL14

      assign cmd_wr[c] = wr_acc & (idx == CIDX) & (cmd.sel == 2'h0); // RL10
      assign eoi_ev[c] = cmd_wr[c] & cmd.code[0];

      always_comb begin
         set_v = 8'h00;
         clr_v = 8'h00;
         base_ld = 1'b0;
         base_val = base_ff[c];
         if (acc[c] & ~auto_end_ff[c]) begin
            set_v[win[c]] = 1'b1;
         end
         if (acc[c] & auto_end_ff[c] & rot_auto_ff[c]) begin
            base_ld = 1'b1; // RL13
            base_val = win[c]; // RL14
         end
         if (cmd_wr[c]) begin
            case (cmd.code)
               `PIC_OP_NS_EOI: begin
                  clr_v[isr_line] = isr_any; // RL7 RL15
               end
               `PIC_OP_SP_EOI: begin
                  clr_v[cmd.level] = 1'b1; // RL7 RL11 RL15
               end
               `PIC_OP_ROT_NS: begin
                  clr_v[isr_line] = isr_any; // RL7
                  base_ld = isr_any;
                  base_val = isr_line; // RL14
               end
               `PIC_OP_SET_PRIO: begin
                  base_ld = 1'b1; // RL8
                  base_val = cmd.level; // RL11
               end
               `PIC_OP_ROT_SP: begin
                  clr_v[cmd.level] = 1'b1; // RL9
                  base_ld = 1'b1;
                  base_val = cmd.level; // RL9
               end
               default: begin
               end
            endcase
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mask_ff[c] <= `PIC_MASK_RST;
         end else if (wr_acc & (idx == MIDX)) begin
            mask_ff[c] <= pwdata[7:0]; // RL1 RL2
         end
      end

      // a new acknowledge wins over a clear of the same bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            isr_ff[c] <= 8'h00;
         end else if (init_pulse) begin
            isr_ff[c] <= 8'h00; // RL4
         end else begin
            isr_ff[c] <= (isr_ff[c] & ~clr_v) | set_v; // RL13 RL15
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            base_ff[c] <= `PIC_BASE_RST; // RL4
         end else if (init_pulse) begin
            base_ff[c] <= `PIC_BASE_RST; // RL4
         end else if (base_ld) begin
            base_ff[c] <= base_val;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rot_auto_ff[c] <= 1'b0; // RL5
         end else if (init_pulse) begin
            rot_auto_ff[c] <= 1'b0; // RL5
         end else if (cmd_wr[c] & (cmd.code == `PIC_OP_ROT_AUTO_CLR)) begin
            rot_auto_ff[c] <= 1'b0; // RL6
         end else if (cmd_wr[c] & (cmd.code == `PIC_OP_ROT_AUTO_SET)) begin
            rot_auto_ff[c] <= 1'b1; // RL6
         end
      end
   end

   assign intr = intr_w[0];

   // ***********************
   // configuration and acknowledge
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_end_ff <= 2'h0;
      end else if (wr_acc & (idx == `PIC_IDX_CFG)) begin
         auto_end_ff <= {pwdata[`PIC_CFG_AUTO_S], pwdata[`PIC_CFG_AUTO_M]}; // RL13
      end
   end

   pic_ack_type ack_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_ff <= '0;
      end else begin
         ack_ff.valid <= acc[0];
         ack_ff.line <= acc[1] ? {1'b1, win[1]} : {1'b0, win[0]}; // RL11
      end
   end
   assign ack_valid = ack_ff.valid;
   assign ack_line = ack_ff.line;

   // ***********************
   // event status, enable, clear
   // ***********************
   logic [3:0] stat_ff;
   logic [3:0] en_ff;
   logic [3:0] ev;
   logic [3:0] clr_w;

   assign ev = {eoi_ev[1], eoi_ev[0], acc[1], acc[0]};
   assign clr_w = (wr_acc & (idx == `PIC_IDX_CLR)) ? pwdata[3:0] : 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_ff <= 4'h0;
      end else begin
         stat_ff <= (stat_ff & ~clr_w) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_ff <= 4'h0;
      end else if (wr_acc & (idx == `PIC_IDX_EN)) begin
         en_ff <= pwdata[3:0];
      end
   end

   assign irq_out = |(stat_ff & en_ff);

   // ***********************
   // read data, captured in the setup cycle
   // ***********************
   logic [31:0] prdata_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0;
      end else if (psel & ~penable) begin
         case (idx)
            `PIC_IDX_MMASK: prdata_ff <= {24'h0, mask_ff[0]};
            `PIC_IDX_SMASK: prdata_ff <= {24'h0, mask_ff[1]};
            `PIC_IDX_CFG: prdata_ff <= {30'h0, auto_end_ff};
            `PIC_IDX_STAT: prdata_ff <= {28'h0, stat_ff};
            `PIC_IDX_EN: prdata_ff <= {28'h0, en_ff};
            `PIC_IDX_ISR: prdata_ff <= {16'h0, isr_ff[1], isr_ff[0]};
            `PIC_IDX_PEND: prdata_ff <= {16'h0, pend_w[1], pend_w[0]};
            default: prdata_ff <= 32'h0;
         endcase
      end
   end
   assign prdata = prdata_ff;

   // ***********************
   // checks
   // ***********************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_mask_blocks: assert property ( // RL1
      intr_w[0] |-> (req_w[0][win[0]] && !mask_ff[0][win[0]]))
      else $error("master request raised from masked lines only");

   chk_unmask_accept: assert property ( // RL2
      (mask_ff[0] == 8'h00 && isr_ff[0] == 8'h00 && req_w[0] != 8'h00) |-> intr_w[0])
      else $error("unmasked request not presented");

   chk_cascade_mask: assert property ( // RL3
      mask_ff[0][2] |-> !acc[1])
      else $error("slave acknowledged while master line 2 masked");

   chk_cascade_feed: assert property ( // RL12
      (intr_w[1] && !mask_ff[0][2] && isr_ff[0] == 8'h00) |-> intr_w[0])
      else $error("slave request did not reach the master");

   chk_init_nested: assert property ( // RL4
      init_pulse |=> (base_ff[0] == 3'h7 && isr_ff == 16'h0000 && base_ff[1] == 3'h7))
      else $error("init did not restore fully nested order");

   chk_init_modes: assert property ( // RL5
      init_pulse |=> (rot_auto_ff == 2'b00))
      else $error("init left rotation enabled");

   chk_rot_auto_cmd: assert property ( // RL6
      (cmd_wr[0] && cmd.code == 3'h4)
      |=> rot_auto_ff[0] ##1 (rot_auto_ff[0] || $past(cmd_wr[0]) || $past(init_pulse)))
      else $error("rotate in automatic end mode not set");

   chk_spec_eoi: assert property ( // RL7
      (cmd_wr[0] && cmd.code == 3'h3 && !acc[0] && !init_pulse)
      |=> !isr_ff[0][$past(pwdata[2:0])])
      else $error("specific end left the line in service");

   chk_set_prio: assert property ( // RL8
      (cmd_wr[0] && cmd.code == 3'h6 && !init_pulse)
      |=> base_ff[0] == $past(pwdata[2:0]))
      else $error("set priority did not load the lowest line");

   chk_rot_spec: assert property ( // RL9
      (cmd_wr[1] && cmd.code == 3'h7 && !acc[1] && !init_pulse)
      |=> (base_ff[1] == $past(pwdata[2:0]) && !isr_ff[1][$past(pwdata[2:0])]))
      else $error("rotate on specific end failed");

   chk_bad_select: assert property ( // RL10
      (wr_acc && idx == 10'h020 && pwdata[4:3] != 2'b00 && !acc[0])
      |=> ($stable(isr_ff[0]) && $stable(base_ff[0]) && $stable(rot_auto_ff[0])))
      else $error("command with bad select bits acted");

   chk_auto_no_isr: assert property ( // RL13
      (acc[0] && auto_end_ff[0] && !cmd_wr[0] && !init_pulse) |=> $stable(isr_ff[0]))
      else $error("automatic end mode set an in-service bit");

   chk_ack_line: assert property ( // RL11
      acc[1] |=> (ack_valid && ack_line == {1'b1, $past(win[1])})
      ##1 (!ack_valid || $past(acc[0])))
      else $error("cascaded acknowledge reported the wrong line");

endmodule
`default_nettype wire

/* File: verif/pic_host_model.sv */
// host processor stand-in: takes one interrupt per request
`default_nettype none
module pic_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic intr,
   input wire logic ack_valid,
   input wire logic [3:0] ack_line,
   input wire logic req,
   input wire logic [3:0] dly,
   output logic int_ack,
   output logic [3:0] seen_line,
   output logic [7:0] seen_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic done_ff;
   logic [3:0] wait_ff;
   // **********
   // acknowledge, prompt or after dly cycles
   // **********
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_ack <= 1'b0;
         done_ff <= 1'b0;
         wait_ff <= 4'h0;
         seen_line <= 4'h0;
         seen_cnt <= 8'h00;
      end else begin
         int_ack <= 1'b0;
         if (ack_valid) begin
            seen_line <= ack_line;
            seen_cnt <= seen_cnt + 8'h01;
         end
         if (!req) begin
            done_ff <= 1'b0;
            wait_ff <= 4'h0;
         end else if (!done_ff && intr) begin
            if (wait_ff >= dly) begin
               int_ack <= 1'b1;
               done_ff <= 1'b1;
            end else begin
               wait_ff <= wait_ff + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/pic_mask_and_eoi_commands_test.sv */
// self-checking bench for the cascaded controller pair
`include "pic_defs.svh"
`default_nettype none
module pic_mask_and_eoi_commands_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [11:0] MCMD = {`PIC_IDX_MCMD, 2'b00}, MMASK = {`PIC_IDX_MMASK, 2'b00};
   localparam logic [11:0] SCMD = {`PIC_IDX_SCMD, 2'b00}, SMASK = {`PIC_IDX_SMASK, 2'b00};
   localparam logic [11:0] CFG = {`PIC_IDX_CFG, 2'b00}, STAT = {`PIC_IDX_STAT, 2'b00};
   localparam logic [11:0] EN = {`PIC_IDX_EN, 2'b00}, CLR = {`PIC_IDX_CLR, 2'b00};
   localparam logic [11:0] ISR = {`PIC_IDX_ISR, 2'b00}, PEND = {`PIC_IDX_PEND, 2'b00};
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic [15:0] irq_in = 0;
   logic [3:0] dly = 0, ack_line, seen_line;
   logic pready, pslverr, intr, int_ack, ack_valid, irq_out, rerr;
   logic [7:0] seen_cnt;
   int bad_count = 0, num_checks = 0;
   always #4 pclk = ~pclk;
   pic_top pic_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_in(irq_in), .intr(intr), .int_ack(int_ack),
      .ack_valid(ack_valid), .ack_line(ack_line), .irq_out(irq_out));
   pic_host_model pic_host_model_inst (.pclk(pclk), .presetn(presetn), .intr(intr),
      .ack_valid(ack_valid), .ack_line(ack_line), .req(req), .dly(dly), .int_ack(int_ack),
      .seen_line(seen_line), .seen_cnt(seen_cnt));
   // **********
   // shared tasks
   // **********
   task automatic tally_and_finish;
      if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, rdat);
   endtask
   task automatic pins(input logic [15:0] v);
      irq_in <= v;
      repeat (4) @(posedge pclk);
   endtask
   task automatic look(input logic ei, input logic eo);
      @(negedge pclk);
      chk("intr", {31'h0, ei}, {31'h0, intr});
      chk("irq_out", {31'h0, eo}, {31'h0, irq_out});
      @(posedge pclk);
   endtask
   task automatic ackc(input logic [3:0] e);
      logic [7:0] c;
      c = seen_cnt;
      req <= 1'b1;
      while (seen_cnt === c) @(posedge pclk);
      req <= 1'b0;
      chk("ack_line", {28'h0, e}, {28'h0, seen_line});
      @(posedge pclk);
   endtask
   // **********
   // scenarios
   // **********
   task automatic t_reset;
      rdc("mmask", MMASK, 32'h0);
      rdc("smask", SMASK, 32'h0);
      rdc("mcmd", MCMD, 32'h0);
      bus(1'b0, 12'hffc, 32'h0);
      chk("pslverr", 32'h1, {31'h0, rerr});
   endtask
   task automatic t_mask;
      pins(16'h0008);
      bus(1'b1, MMASK, 32'h08);
      look(1'b0, 1'b0);
      rdc("pend", PEND, 32'h0);
      rdc("mmask", MMASK, 32'h08);
      bus(1'b1, MMASK, 32'h00);
      look(1'b1, 1'b0);
      rdc("pend", PEND, 32'h08);
      pins(16'h0);
   endtask
   task automatic t_cascade;
      pins(16'h0400);
      bus(1'b1, MMASK, 32'h04);
      look(1'b0, 1'b0);
      bus(1'b1, MMASK, 32'h00);
      look(1'b1, 1'b0);
      bus(1'b1, SMASK, 32'h04);
      look(1'b0, 1'b0);
      rdc("smask", SMASK, 32'h04);
      bus(1'b1, SMASK, 32'h00);
      look(1'b1, 1'b0);
      dly <= 4'h3;
      ackc(4'ha);
      dly <= 4'h0;
      rdc("isr", ISR, 32'h0404);
      pins(16'h0);
      bus(1'b1, SCMD, 32'h20);
      bus(1'b1, MCMD, 32'h20);
      bus(1'b1, SCMD, 32'he2);
      bus(1'b1, SCMD, 32'hc7);
      rdc("isr", ISR, 32'h0);
      rdc("stat", STAT, 32'hf);
   endtask
   task automatic t_nested;
      pins(16'h0020);
      ackc(4'h5);
      look(1'b0, 1'b0);
      pins(16'h0022);
      look(1'b1, 1'b0);
      ackc(4'h1);
      bus(1'b1, MCMD, 32'h28);
      rdc("isr", ISR, 32'h22);
      bus(1'b1, MCMD, 32'h20);
      rdc("isr", ISR, 32'h20);
      bus(1'b1, MCMD, 32'h40);
      rdc("isr", ISR, 32'h20);
      bus(1'b1, MCMD, 32'h65);
      rdc("isr", ISR, 32'h0);
      pins(16'h0);
   endtask
   task automatic t_rotate;
      pins(16'h0011);
      ackc(4'h0);
      bus(1'b1, MCMD, 32'ha0);
      ackc(4'h4);
      bus(1'b1, MCMD, 32'he4);
      ackc(4'h0);
      bus(1'b1, MCMD, 32'hc3);
      ackc(4'h4);
      rdc("isr", ISR, 32'h11);
      bus(1'b1, MCMD, 32'h60);
      bus(1'b1, MCMD, 32'h64);
      rdc("isr", ISR, 32'h0);
      pins(16'h0);
   endtask
   task automatic t_auto;
      bus(1'b1, MCMD, 32'hc7);
      bus(1'b1, CFG, 32'h01);
      pins(16'h0011);
      ackc(4'h0);
      rdc("isr", ISR, 32'h0);
      bus(1'b1, MCMD, 32'h80);
      ackc(4'h0);
      ackc(4'h4);
      bus(1'b1, MCMD, 32'h00);
      ackc(4'h0);
      ackc(4'h0);
      pins(16'h0);
      bus(1'b1, CFG, 32'h02);
      pins(16'h0100);
      ackc(4'h8);
      rdc("isr", ISR, 32'h4);
      bus(1'b1, MCMD, 32'h20);
      bus(1'b1, CFG, 32'h00);
      pins(16'h0);
   endtask
   task automatic t_init;
      bus(1'b1, MCMD, 32'hc3);
      pins(16'h0011);
      ackc(4'h4);
      bus(1'b1, MMASK, 32'h02);
      bus(1'b1, CFG, 32'h10);
      rdc("isr", ISR, 32'h0);
      rdc("mmask", MMASK, 32'h02);
      ackc(4'h0);
      bus(1'b1, MCMD, 32'h20);
      bus(1'b1, MMASK, 32'h00);
      pins(16'h0);
   endtask
   task automatic t_irq;
      bus(1'b1, CLR, 32'hf);
      rdc("stat", STAT, 32'h0);
      bus(1'b1, EN, 32'h1);
      pins(16'h0001);
      look(1'b1, 1'b0);
      ackc(4'h0);
      look(1'b0, 1'b1);
      rdc("stat", STAT, 32'h1);
      bus(1'b1, EN, 32'h0);
      look(1'b0, 1'b0);
      bus(1'b1, EN, 32'h1);
      bus(1'b1, CLR, 32'h1);
      look(1'b0, 1'b0);
      rdc("en", EN, 32'h1);
      rdc("clr", CLR, 32'h0);
      bus(1'b1, MCMD, 32'h20);
      rdc("stat", STAT, 32'h4);
      bus(1'b1, EN, 32'h0);
      pins(16'h0);
   endtask
   // **********
   // main sequence and watchdog
   // **********
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_mask;
      t_cascade;
      t_nested;
      t_rotate;
      t_auto;
      t_init;
      t_irq;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
